// file: design/chan_ctl_pkg.sv
// constants, types and state layout for the channel acquisition control
//
// Notes on behaviour
// - normal mode only after all four responded
// - new site sends call-on, starts search, timer
// - call-on repeats every major frame while waiting
// - reply accepted only from coarse lock on
// - verified in time: call-on becomes track
// - newest site timed out: fetch its alternate
// - track sent during coarse lock until status
// - status change moves code control to fine search
// - fine code lock gives full track
// - full track, healthy: reload address enables memory
// - no reload: range below maximum does nothing
// - range at maximum, doppler negative: standby message
// - release idles code control, fetches new site
// - drop in coarse lock: idle, standby, timer reset
// - next major frame: call-on again
// - reacquire timeout: oldest new, newest alternate
// - drop in fine states waits for idle
// - reload in progress sends load-memory
// - parity error sends error, reload resent
// - message is three bits, fixed encodings
// - channel n served in minor frame n
package chan_ctl_pkg;
	localparam int NCH = 4;
	localparam int SITE_W = 6;
	localparam int RMAX_W = 12;
	localparam int TMR_W = 28;
	localparam int REPLY_SYNC_W = 3;
	localparam int REPLY_STAT_W = 1;
	localparam int REPLY_W = REPLY_SYNC_W + SITE_W + REPLY_STAT_W;
	localparam int CLK_MHZ = 50;
	localparam int CALL_MS = 4000;
	localparam int CALL_CYC = CALL_MS * 1000 * CLK_MHZ;
	localparam logic [2:0] MSG_STBY = 3'h0;
	localparam logic [2:0] MSG_ON = 3'h7;
	localparam logic [2:0] MSG_TRACK = 3'h5;
	localparam logic [2:0] MSG_LOAD = 3'h4;
	localparam logic [2:0] MSG_ERR = 3'h7;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_CHST = 8'h08;
	localparam logic [7:0] A_SITE = 8'h0C;
	localparam int CTRL_EN = 0;

	typedef enum logic [2:0] {CC_V0, CC_V1, CC_V2, CC_V3, CC_V4} cc_t;
	typedef enum logic [2:0] {
		PH_IDLE, PH_CALL, PH_TRACK, PH_LOAD, PH_ERR, PH_STBY, PH_WAIT
	} ph_t;

	typedef struct packed {
		logic valid;
		logic [1:0] chan;
		logic [SITE_W-1:0] site;
		logic status;
	} rx_t;

	typedef struct packed {
		logic valid;
		logic [1:0] chan;
		logic [RMAX_W-1:0] val;
		logic neg;
	} rng_t;

	typedef struct packed {
		logic valid;
		logic [SITE_W-1:0] site;
		logic [RMAX_W-1:0] rmax;
	} mem_rsp_t;

	typedef struct packed {
		logic req;
		logic alt;
		logic [1:0] chan;
	} mem_req_t;

	typedef struct packed {
		logic stb;
		logic [1:0] chan;
		logic [2:0] msg;
		logic [SITE_W-1:0] site;
	} tx_t;

	typedef struct packed {
		ph_t ph;
		cc_t cc;
		logic [SITE_W-1:0] site;
		logic [RMAX_W-1:0] rmax;
		logic alt;
		logic [1:0] age;
		logic [TMR_W-1:0] tmr;
		logic stat;
		logic resp;
		logic need;
	} ch_t;

	typedef struct packed {
		ch_t [NCH-1:0] ch;
		logic [1:0] slot;
		logic en;
		logic normal;
		logic mbusy;
		mem_req_t mreq;
		tx_t tx;
		logic [NCH-1:0] reload;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} st_t;
endpackage

// file: design/chan_ctl.sv
// per-channel call, track, release and reload control with apb registers
`timescale 1ns/100ps
module chan_ctl import chan_ctl_pkg::*; #(
	parameter int unsigned TIMEOUT_CYC = CALL_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic major_pulse,
	input wire logic minor_pulse,
	input wire rx_t rx,
	input wire rng_t rng,
	input wire mem_rsp_t mem_rsp,
	input wire logic [NCH-1:0] coarse_lock,
	input wire logic [NCH-1:0] hcode_lock,
	input wire logic [NCH-1:0] cc_home,
	input wire logic [NCH-1:0] dropout,
	input wire logic [NCH-1:0] chan_ok,
	input wire logic [NCH-1:0] reload_addr,
	input wire logic [NCH-1:0] parity_err,
	input wire logic [NCH-1:0] reload_done,
	output tx_t tx,
	output mem_req_t mem_req,
	output logic [NCH-1:0] reload_en,
	output cc_t [NCH-1:0] cc_state,
	output logic normal_mode
);
	st_t st_r;
	st_t st_nxt;
	logic [NCH-1:0] resp_w;

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign tx = st_r.tx;
	assign mem_req = st_r.mreq;
	assign reload_en = st_r.reload;
	assign normal_mode = st_r.normal;

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			resp_w[i] = st_r.ch[i].resp;
			cc_state[i] = st_r.ch[i].cc;
		end
	end

	function automatic logic [2:0] code_of(ph_t p);
		unique case (p)
			PH_CALL: code_of = MSG_ON;
			PH_TRACK, PH_WAIT: code_of = MSG_TRACK;
			PH_LOAD: code_of = MSG_LOAD;
			PH_ERR: code_of = MSG_ERR;
			PH_IDLE, PH_STBY: code_of = MSG_STBY;
		endcase
	endfunction

	always_comb begin
		ch_t n;
		logic expd;
		logic [1:0] slot;
		logic [1:0] oldage;
		logic [31:0] rd;
		logic [NCH*6-1:0] chst;
		logic [NCH*SITE_W-1:0] sites;
		n = st_r.ch[0];
		expd = 1'b0;
		slot = st_r.slot;
		oldage = '0;
		rd = '0;
		chst = '0;
		sites = '0;
		st_nxt = st_r;
		st_nxt.tx.stb = 1'b0;
		st_nxt.mreq.req = 1'b0;

		for (int i = 0; i < NCH; i++) begin
			chst[i*6 +: 6] = {st_r.ch[i].cc, st_r.ch[i].ph};
			sites[i*SITE_W +: SITE_W] = st_r.ch[i].site;
		end

		// apb: one wait state, answer registered
		st_nxt.pready = psel & penable & ~st_r.pready;
		st_nxt.pslverr = 1'b0;
		if (st_nxt.pready) begin
			case (paddr)
				A_CTRL: begin
					rd = 32'(st_r.en);
					if (pwrite) begin
						st_nxt.en = pwdata[CTRL_EN];
					end
				end
				A_STAT: rd = 32'({st_r.normal, resp_w});
				A_CHST: rd = 32'(chst);
				A_SITE: rd = 32'(sites);
				default: begin
					st_nxt.pslverr = 1'b1;
				end
			endcase
			st_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
		end

		// one slot per minor frame, the major pulse opens slot zero
		if (minor_pulse) begin
			slot = major_pulse ? 2'h0 : 2'(st_r.slot + 2'h1);
			st_nxt.slot = slot;
			st_nxt.tx.stb = 1'b1;
			st_nxt.tx.chan = slot;
			st_nxt.tx.site = st_r.ch[slot].site;
			// call-on goes out once a frame while calling
			st_nxt.tx.msg = st_r.en ? code_of(st_r.ch[slot].ph) : MSG_STBY;
		end

		if (st_r.en) begin
			for (int i = 0; i < NCH; i++) begin
				n = st_r.ch[i];
				expd = n.tmr == TMR_W'(TIMEOUT_CYC - 1);
				if (n.ph == PH_CALL) begin
					n.tmr = expd ? '0 : TMR_W'(n.tmr + 1'b1);
				end
				// timer only matters until the station has responded
				if (n.ph == PH_CALL && expd) begin
					if (!st_r.normal) begin
						n.tmr = '0;
					end else if (n.age == '0) begin
						n.ph = PH_IDLE;
						n.cc = CC_V0;
						n.need = 1'b1;
						n.alt = 1'b0;
						n.resp = 1'b0;
					end else if (n.age == 2'(NCH - 1)) begin
						n.ph = PH_IDLE;
						n.cc = CC_V0;
						n.need = 1'b1;
						n.alt = ~n.alt;
						n.resp = 1'b0;
					end
				end
				if (n.cc == CC_V1 && coarse_lock[i]) begin
					n.cc = CC_V2;
				end
				// reply word is decoded upstream to site and status
				// a lock that arrives with the reply does not open the gate
				if (rx.valid && rx.chan == 2'(i) && n.cc >= CC_V2 &&
					st_r.ch[i].cc >= CC_V2) begin
					if (n.ph == PH_CALL && rx.site == n.site && !expd) begin
						n.ph = PH_TRACK;
						n.resp = 1'b1;
						n.stat = rx.status;
					end else if (n.ph == PH_TRACK && n.cc == CC_V2 &&
						rx.status != n.stat) begin
						n.cc = CC_V3;
						n.stat = rx.status;
					end
					// otherwise track keeps going out in coarse lock
				end
				if (n.cc == CC_V3 && st_r.ch[i].cc == CC_V3 &&
					hcode_lock[i]) begin
					n.cc = CC_V4;
				end
				if (n.cc == CC_V4) begin
					unique case (n.ph)
						PH_TRACK: begin
							// reload address from a sound full-track channel
							if (reload_addr[i] && chan_ok[i]) begin
								n.ph = PH_LOAD;
							end else if (!reload_addr[i] && rng.valid &&
								rng.chan == 2'(i) && st_r.normal) begin
								// below maximum nothing happens
								if (rng.val >= n.rmax && rng.neg) begin
									n.ph = PH_IDLE;
									n.cc = CC_V0;
									n.need = 1'b1;
									n.alt = 1'b0;
									n.resp = 1'b0;
								end
							end
						end
						PH_LOAD: begin
							if (parity_err[i]) begin
								n.ph = PH_ERR;
							end else if (reload_done[i]) begin
								n.ph = PH_TRACK;
							end
						end
						PH_ERR: begin
							if (reload_addr[i]) begin
								n.ph = PH_LOAD;
							end
						end
						default: begin
						end
					endcase
				end
				// drop-out handling is last so it overrides the steps above
				if (dropout[i] && st_r.ch[i].cc == CC_V2 &&
					(st_r.ch[i].ph == PH_CALL ||
					st_r.ch[i].ph == PH_TRACK)) begin
					n.ph = PH_STBY;
					n.cc = CC_V0;
					n.tmr = '0;
					n.need = 1'b0;
					n.alt = st_r.ch[i].alt;
				end else if (dropout[i] &&
					st_r.ch[i].cc >= CC_V3) begin
					n.ph = PH_WAIT;
				end else if (n.ph == PH_WAIT && cc_home[i]) begin
					n.ph = PH_STBY;
					n.cc = CC_V0;
					n.tmr = '0;
				end else if (n.ph == PH_STBY && major_pulse) begin
					n.ph = PH_CALL;
					n.cc = CC_V1;
					n.tmr = '0;
				end
				st_nxt.ch[i] = n;
				st_nxt.reload[i] = n.ph == PH_LOAD;
			end

			// one memory fetch at a time, lowest channel first
			if (st_r.mbusy && mem_rsp.valid) begin
				st_nxt.mbusy = 1'b0;
				n = st_nxt.ch[st_r.mreq.chan];
				oldage = n.age;
				n.site = mem_rsp.site;
				n.rmax = mem_rsp.rmax;
				n.need = 1'b0;
				n.ph = PH_CALL;
				n.cc = CC_V1;
				n.tmr = '0;
				st_nxt.ch[st_r.mreq.chan] = n;
				// a prime fetch makes this site the newest
				if (!st_r.mreq.alt) begin
					for (int i = 0; i < NCH; i++) begin
						if (st_nxt.ch[i].age > oldage) begin
							st_nxt.ch[i].age = 2'(st_nxt.ch[i].age - 2'h1);
						end
					end
					st_nxt.ch[st_r.mreq.chan].age = 2'(NCH - 1);
				end
			end else if (!st_r.mbusy) begin
				for (int i = NCH - 1; i >= 0; i--) begin
					if (st_r.ch[i].need) begin
						st_nxt.mreq.chan = 2'(i);
						st_nxt.mreq.alt = st_r.ch[i].alt;
					end
				end
				if (|{st_r.ch[3].need, st_r.ch[2].need,
					st_r.ch[1].need, st_r.ch[0].need}) begin
					st_nxt.mreq.req = 1'b1;
					st_nxt.mbusy = 1'b1;
				end
			end
			if (&resp_w) begin
				st_nxt.normal = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			for (int i = 0; i < NCH; i++) begin
				st_r.ch[i].need <= 1'b1;
				st_r.ch[i].age <= 2'(i);
			end
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_drop;
		ce && st_r.en && dropout[0] && st_r.ch[0].cc == CC_V2 &&
			st_r.ch[0].ph inside {PH_CALL, PH_TRACK};
	endsequence
	sequence s_stby;
		st_r.ch[0].ph == PH_STBY && st_r.ch[0].cc == CC_V0 &&
			st_r.ch[0].tmr == '0;
	endsequence

	property p_norm;
		$rose(st_r.normal) |-> $past(&resp_w);
	endproperty
	a_norm: assert property (p_norm)
		else $error("normal mode without all responded");

	property p_gate;
		ce && st_r.en && rx.valid && rx.chan == 2'h0 &&
			st_r.ch[0].cc == CC_V1 && st_r.ch[0].ph == PH_CALL
			|=> st_r.ch[0].ph != PH_TRACK;
	endproperty
	a_gate: assert property (p_gate)
		else $error("reply taken before coarse lock");

	property p_verify;
		ce && st_r.en && rx.valid && rx.chan == 2'h0 && !dropout[0] &&
			st_r.ch[0].cc == CC_V2 && st_r.ch[0].ph == PH_CALL &&
			rx.site == st_r.ch[0].site &&
			st_r.ch[0].tmr != TMR_W'(TIMEOUT_CYC - 1)
			|=> st_r.ch[0].ph == PH_TRACK && st_r.ch[0].resp;
	endproperty
	a_verify: assert property (p_verify)
		else $error("verified site did not switch to track");

	property p_stat;
		ce && st_r.en && rx.valid && rx.chan == 2'h0 && !dropout[0] &&
			st_r.ch[0].cc == CC_V2 && st_r.ch[0].ph == PH_TRACK &&
			rx.status != st_r.ch[0].stat |=> st_r.ch[0].cc == CC_V3;
	endproperty
	a_stat: assert property (p_stat)
		else $error("status change did not start fine search");

	property p_drop;
		s_drop |=> s_stby;
	endproperty
	a_drop: assert property (p_drop)
		else $error("drop in coarse lock not handled");

	property p_recall;
		ce && st_r.en && major_pulse && !dropout[0] &&
			st_r.ch[0].ph == PH_STBY
			|=> st_r.ch[0].ph == PH_CALL && st_r.ch[0].cc == CC_V1;
	endproperty
	a_recall: assert property (p_recall)
		else $error("no call-on after standby frame");

	property p_rel;
		ce && st_r.en && st_r.normal && rng.valid && rng.chan == 2'h0 &&
			!reload_addr[0] && !dropout[0] && st_r.ch[0].cc == CC_V4 &&
			st_r.ch[0].ph == PH_TRACK && rng.neg &&
			rng.val >= st_r.ch[0].rmax
			|=> st_r.ch[0].ph == PH_IDLE && st_r.ch[0].cc == CC_V0 &&
			st_r.ch[0].need;
	endproperty
	a_rel: assert property (p_rel)
		else $error("range limit did not release station");

	property p_slot;
		ce && minor_pulse && !major_pulse
			|=> tx.stb && tx.chan == 2'($past(st_r.slot) + 2'h1);
	endproperty
	a_slot: assert property (p_slot)
		else $error("slot did not advance");

	property p_msg;
		ce && minor_pulse && major_pulse && st_r.en &&
			st_r.ch[0].ph == PH_TRACK |=> tx.chan == 2'h0 &&
			tx.msg == MSG_TRACK;
	endproperty
	a_msg: assert property (p_msg)
		else $error("wrong track code in slot zero");

	property p_hlock;
		ce && st_r.en && !dropout[0] && st_r.ch[0].cc == CC_V3 &&
			st_r.ch[0].ph == PH_TRACK && hcode_lock[0]
			|=> st_r.ch[0].cc == CC_V4;
	endproperty
	a_hlock: assert property (p_hlock)
		else $error("fine code lock did not give full track");

	property p_load;
		ce && st_r.en && !dropout[0] && st_r.ch[0].cc == CC_V4 &&
			st_r.ch[0].ph == PH_TRACK && reload_addr[0] && chan_ok[0]
			|=> st_r.ch[0].ph == PH_LOAD && reload_en[0];
	endproperty
	a_load: assert property (p_load)
		else $error("reload request did not start load-memory");

	property p_parity;
		ce && st_r.en && !dropout[0] && st_r.ch[0].cc == CC_V4 &&
			st_r.ch[0].ph == PH_LOAD && parity_err[0]
			|=> st_r.ch[0].ph == PH_ERR && !reload_en[0];
	endproperty
	a_parity: assert property (p_parity)
		else $error("parity error did not switch to error");

	property p_fetch;
		ce && st_r.en && !st_r.mbusy && st_r.ch[0].need
			|=> mem_req.req && mem_req.chan == 2'h0;
	endproperty
	a_fetch: assert property (p_fetch)
		else $error("released channel did not ask for a site");
endmodule

// file: verification/site_mem_model.sv
// memory-side model that answers site requests, promptly or slowly
`timescale 1ns/100ps
module site_mem_model import chan_ctl_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire mem_req_t mem_req,
	output mem_rsp_t mem_rsp
);
	logic [5:0] dly_r;
	mem_req_t hold_r;
	// the slow answer leaves a whole frame between release and refill
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_r <= 6'h00;
			hold_r <= '0;
			mem_rsp <= '0;
		end else begin
			mem_rsp <= '0;
			if (mem_req.req) begin
				hold_r <= mem_req;
				dly_r <= slow ? 6'h28 : 6'h01;
			end else if (dly_r == 6'h01) begin
				dly_r <= 6'h00;
				// alternate sites differ in the top bit
				mem_rsp <= '{1'b1, {hold_r.alt, hold_r.chan, 3'h5}, 12'h200};
			end else if (dly_r != 6'h00) begin
				dly_r <= dly_r - 6'h01;
			end
		end
	end
endmodule

// file: verification/test_chan_ctl.sv
// self-checking bench for the channel acquisition control
`timescale 1ns/100ps
module test_chan_ctl;
	import chan_ctl_pkg::*;
	localparam int TMO = 400;
	localparam int LCK = 0, HLK = 1, DRP = 2, RLD = 3, PAR = 4;
	localparam int DONE = 5, HOME = 6;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce, psel, penable, pwrite, pready, pslverr, err, slow;
	logic major_pulse, minor_pulse, normal_mode;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	rx_t rx;
	rng_t rng;
	mem_rsp_t mem_rsp;
	mem_req_t mem_req;
	tx_t tx;
	logic [NCH-1:0] coarse_lock, hcode_lock, cc_home, dropout, chan_ok;
	logic [NCH-1:0] reload_addr, parity_err, reload_done, reload_en;
	cc_t [NCH-1:0] cc_state;
	int fail_count = 0;
	int comparisons = 0;
	int req_cnt = 0;
	int cyc = 0;
	int n;

	chan_ctl #(.TIMEOUT_CYC(TMO)) chan_ctl_inst (.pclk, .presetn, .ce,
		.paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .major_pulse, .minor_pulse, .rx, .rng, .mem_rsp,
		.coarse_lock, .hcode_lock, .cc_home, .dropout, .chan_ok,
		.reload_addr, .parity_err, .reload_done, .tx, .mem_req,
		.reload_en, .cc_state, .normal_mode);
	site_mem_model site_mem_model_inst (.pclk, .presetn, .slow, .mem_req,
		.mem_rsp);

	always #10 pclk = ~pclk;

	always @(posedge pclk) begin
		cyc++;
		if (mem_req.req === 1'b1)
			req_cnt++;
		if (cyc == 5000) begin
			fail_count++;
			finish_test;
		end
	end

	task finish_test;
		if (fail_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task tick(input int k);
		repeat (k) @(posedge pclk);
	endtask

	function logic [SITE_W-1:0] site_of(input int ch, input logic alt);
		return {alt, 2'(ch), 3'h5};
	endfunction

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// one major frame; slot ch is compared once its strobe has landed
	task frame(input int ch, input logic [2:0] m, input logic maj);
		for (int s = 0; s < NCH; s++) begin
			major_pulse <= maj && s == 0;
			minor_pulse <= 1'b1;
			tick(1);
			major_pulse <= 1'b0;
			minor_pulse <= 1'b0;
			tick(1);
			if (s == ch)
				chk("tx_stb", 1, tx.stb);
			tick(2);
			if (s == ch) begin
				chk("tx_chan", ch, tx.chan);
				chk("tx_msg", m, tx.msg);
			end
		end
	endtask

	task ev(input int k, input int ch);
		logic [NCH-1:0] b;
		b = '0;
		b[ch] = 1'b1;
		case (k)
		LCK: coarse_lock <= b;
		HLK: hcode_lock <= b;
		DRP: dropout <= b;
		RLD: reload_addr <= b;
		PAR: parity_err <= b;
		DONE: reload_done <= b;
		default: cc_home <= b;
		endcase
		tick(1);
		{coarse_lock, hcode_lock, dropout} <= '0;
		{reload_addr, parity_err, reload_done, cc_home} <= '0;
		tick(2);
	endtask

	task reply(input int ch, input logic st);
		rx <= '{1'b1, 2'(ch), site_of(ch, 1'b0), st};
		tick(1);
		rx <= '0;
		tick(2);
	endtask

	task rng_ev(input logic [RMAX_W-1:0] v);
		rng <= '{1'b1, 2'h0, v, 1'b1};
		tick(1);
		rng <= '0;
		tick(2);
	endtask

	// waits up to 100 cycles for the code state to arrive before comparing it
	task cc_chk(input int ch, input cc_t e);
		for (int k = 0; k < 100 && cc_state[ch] !== e; k++)
			tick(1);
		chk("cc_state", e, cc_state[ch]);
	endtask

	initial begin
		{ce, psel, penable, pwrite, major_pulse, minor_pulse, slow} = '0;
		paddr = '0;
		pwdata = '0;
		rx = '0;
		rng = '0;
		{coarse_lock, hcode_lock, cc_home, dropout} = '0;
		{reload_addr, parity_err, reload_done} = '0;
		chan_ok = '1;
		ce = 1'b1;
		tick(20);
		presetn <= 1'b1;
		tick(1);
		chk("tx", 0, tx);
		chk("outputs", 0, {mem_req, reload_en, normal_mode, cc_state});
		apb(1'b0, A_CTRL, 0);
		chk("ctrl", 0, rd);
		apb(1'b1, 8'h10, 32'h0000_0001);
		chk("slverr", 1, err);
		frame(0, MSG_STBY, 1'b1);
		apb(1'b1, A_CTRL, 32'h0000_0001);
		apb(1'b0, A_CTRL, 0);
		chk("ctrl", 1, rd);
		for (int c = 0; c < NCH; c++)
			cc_chk(c, CC_V1);
		frame(3, MSG_ON, 1'b1);
		reply(0, 1'b0);
		frame(0, MSG_ON, 1'b1);
		for (int c = 0; c < NCH; c++) begin
			chk("normal", 0, normal_mode);
			ev(LCK, c);
			cc_chk(c, CC_V2);
			reply(c, 1'b0);
		end
		chk("normal", 1, normal_mode);
		frame(2, MSG_TRACK, 1'b1);
		chk("tx_site", site_of(3, 1'b0), tx.site);
		apb(1'b0, A_STAT, 0);
		chk("stat", 32'h0000_001f, rd);
		apb(1'b0, A_SITE, 0);
		chk("site", {site_of(3, 0), site_of(2, 0), site_of(1, 0),
			site_of(0, 0)}, rd);
		reply(0, 1'b1);
		cc_chk(0, CC_V3);
		ev(HLK, 0);
		cc_chk(0, CC_V4);
		chan_ok <= 4'he;
		ev(RLD, 0);
		chk("reload_en", 0, reload_en);
		chan_ok <= 4'hf;
		ev(RLD, 0);
		chk("reload_en", 1, reload_en);
		frame(0, MSG_LOAD, 1'b1);
		ev(PAR, 0);
		frame(0, MSG_ERR, 1'b1);
		ev(RLD, 0);
		ev(DONE, 0);
		chk("reload_en", 0, reload_en);
		frame(0, MSG_TRACK, 1'b1);
		rng_ev(12'h1ff);
		frame(0, MSG_TRACK, 1'b1);
		cc_chk(0, CC_V4);
		slow <= 1'b1;
		n = req_cnt;
		rng_ev(12'h200);
		chk("cc_state", CC_V0, cc_state[0]);
		frame(0, MSG_STBY, 1'b1);
		chk("req_cnt", n + 1, req_cnt);
		chk("req", {1'b0, 2'h0}, {mem_req.alt, mem_req.chan});
		cc_chk(0, CC_V1);
		slow <= 1'b0;
		n = req_cnt;
		for (int k = 0; k < TMO + 200 && req_cnt == n; k++)
			tick(1);
		chk("req", {1'b1, 2'h0}, {mem_req.alt, mem_req.chan});
		cc_chk(0, CC_V1);
		ev(LCK, 0);
		cc_chk(0, CC_V2);
		ev(DRP, 0);
		cc_chk(0, CC_V0);
		ev(DRP, 1);
		cc_chk(1, CC_V0);
		frame(1, MSG_STBY, 1'b0);
		frame(1, MSG_ON, 1'b1);
		reply(2, 1'b1);
		cc_chk(2, CC_V3);
		ev(DRP, 2);
		frame(2, MSG_TRACK, 1'b0);
		cc_chk(2, CC_V3);
		ev(HOME, 2);
		cc_chk(2, CC_V0);
		finish_test;
	end
endmodule
